// ---- key_matrix_scanner_tb_top.sv ----
/*
 * key_matrix_scanner_tb_top: self-checking bench for the scanner over AXI4-Lite.
 * Assumes the kms_key_matrix model on the column pins and a 25 MHz clock.
 */
module key_matrix_scanner_tb_top
	import kms_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic bvalid, rvalid, awready, wready, arready, irq;
	logic [23:0] awaddr, araddr;
	logic [31:0] wdata, rdata, q;
	logic [1:0] bresp, rresp, r;
	logic [KMS_ROWS-1:0] row_oe;
	logic [KMS_COLS-1:0] col_in;
	logic [KMS_KEYS-1:0] pressed;
	// keys of the ghost square, then its marker
	logic [7:0] ghost [5] = '{8'h00, 8'h01, 8'h12, 8'h13, 8'hF9};
	int mismatches, compares, k;
	integer seed; // fixed seed keeps the random draws repeatable
	kms_scanner u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .row_out(), .row_oe(row_oe), .col_in(col_in),
		.key_event_irq(irq));
	kms_key_matrix u_keys (.row_oe(row_oe), .pressed(pressed), .col_in(col_in));
	// free-running 40 ns clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// one bus transfer; ready is looked at on the falling edge, where it has settled
	task automatic bus(input bit w, input logic [23:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic [1:0] rs);
		bit pa, pw, pd, ha, hw;
		@(posedge aclk);
		pa = 1'b1;
		pw = w;
		pd = 1'b0;
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (int n = 0; n < 64 && !pd; n++) begin
			@(negedge aclk);
			ha = pa && (w ? awready : arready);
			hw = pw && wready;
			pd = w ? bvalid : rvalid;
			rq = rdata;
			rs = w ? bresp : rresp;
			@(posedge aclk);
			if (ha) begin
				awvalid <= 1'b0;
				arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (hw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (pd) begin
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		if (!pd) begin
			mismatches++;
			$display("FAIL bus answer expected 1 seen 0");
			end_of_test();
		end
	endtask : bus
	task automatic rd(input logic [23:0] a, input logic [31:0] m, input logic [31:0] e,
		input string s);
		bus(1'b0, a, 32'h0, q, r);
		chk(s, e & m, q & m);
	endtask : rd
	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q, r);
		chk("write resp", {30'h0, KMS_RESP_OKAY}, {30'h0, r});
	endtask : wr
	// bounded wait for the key-event line, looked at on the falling edge where it has settled
	task automatic wirq;
		for (int n = 0; n < 20000 && irq !== 1'b1; n++) @(negedge aclk);
		if (irq !== 1'b1) begin
			mismatches++;
			$display("FAIL irq expected 1 seen %b", irq);
			end_of_test();
		end
	endtask : wirq
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
		{awaddr, araddr, wdata, pressed} = '0;
		seed = 32'h910C;
		mismatches = 0;
		compares = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(KMS_OFF_IRQ_EN, 32'h1, 32'h0, "irq enable");
		rd(KMS_OFF_FLAG, 32'h1, 32'h0, "irq flag");
		rd(KMS_OFF_STATUS, 32'h7, 32'h3, "status");
		rd(KMS_OFF_SRST, 32'h3, 32'h0, "soft reset");
		bus(1'b0, 24'h22601C, 32'h0, q, r);
		chk("unmapped resp", {30'h0, KMS_RESP_SLVERR}, {30'h0, r});
		$display("reset test done");
		// two rows by two columns keeps one scan to 12 ticks
		wr(KMS_OFF_CTRL, 32'h13);
		// press count 2: a press landing mid-scan gives a partial map that must not fire
		wr(KMS_OFF_DEB, 32'h12);
		wr(KMS_OFF_IRQ_EN, 32'h1);
		k = $random(seed) & 3;
		pressed[(k/2)*KMS_COLS+k%2] <= 1'b1;
		wirq();
		rd(KMS_OFF_QUEUE, 32'hFF, (k/2)*KMS_COLS+k%2, "key code");
		rd(KMS_OFF_QUEUE, 32'hFF, KMS_MK_NORMAL, "normal marker");
		rd(KMS_OFF_STATUS, 32'h2, 32'h2, "empty after pops");
		wr(KMS_OFF_FLAG, 32'h0);
		rd(KMS_OFF_FLAG, 32'h1, 32'h1, "flag kept");
		wr(KMS_OFF_FLAG, 32'h1);
		rd(KMS_OFF_FLAG, 32'h1, 32'h0, "flag cleared");
		$display("press test done");
		pressed <= '0;
		wirq();
		rd(KMS_OFF_QUEUE, 32'hFF, KMS_MK_RELEASE, "release marker");
		wr(KMS_OFF_FLAG, 32'h1);
		pressed <= KMS_KEYS'(20'hC0003);
		wirq();
		foreach (ghost[i]) rd(KMS_OFF_QUEUE, 32'hFF, ghost[i], "ghost entry");
		wr(KMS_OFF_FLAG, 32'h1);
		$display("release and ghost tests done");
		// leave a release marker queued and the flag set across the soft reset
		pressed <= '0;
		wirq();
		wr(KMS_OFF_CTRL, 32'h12);
		wr(KMS_OFF_SRST, 32'h1);
		k = 0;
		do begin
			bus(1'b0, KMS_OFF_SRST, 32'h0, q, r);
			k++;
		end while (q[1] !== 1'b0 && k < 50);
		chk("busy", 32'h0, {31'h0, q[1]});
		rd(KMS_OFF_STATUS, 32'h7, 32'h3, "status after soft reset");
		rd(KMS_OFF_FLAG, 32'h1, 32'h1, "flag after soft reset");
		wr(KMS_OFF_IRQ_EN, 32'h0);
		@(negedge aclk);
		chk("irq gated", 32'h0, {31'h0, irq});
		$display("soft reset test done");
		end_of_test();
	end
endmodule : key_matrix_scanner_tb_top

// ---- kms_key_fifo.sv ----
/*
 * kms_key_fifo: 32 entry by 8 bit key queue with a registered head.
 * Assumes the writer never pushes when full and the reader never pops when
 * empty; srst is a synchronous clear from the same clock.
 */
module kms_key_fifo
	import kms_pkg::*;
(
	input wire logic aclk,
	input wire logic srst,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] head,
	output logic [5:0] count
);
	logic [7:0] mem [KMS_DEPTH]; // storage, no reset needed
	logic [KMS_PTR_W-1:0] wr_ptr; // next slot to write
	logic [KMS_PTR_W-1:0] rd_ptr; // slot shown at head
	logic [KMS_PTR_W-1:0] next_rd_ptr; // read pointer after this edge

	// pointer advance on pop
	always_comb begin
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	// storage write
	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge aclk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= count + 6'(push) - 6'(pop);
		end
	end

	// head register; bypass so a push into the shown slot is seen at once
	always_ff @(posedge aclk) begin
		if (srst) begin
			head <= 8'h00;
		end else if (push && (wr_ptr == next_rd_ptr)) begin
			head <= push_data;
		end else begin
			head <= mem[next_rd_ptr];
		end
	end
endmodule : kms_key_fifo

// ---- kms_key_matrix.sv ----
/*
 * kms_key_matrix: switch matrix model standing on the far side of the scanner.
 * Assumes pull-ups on every column and rows that are sunk only while row_oe is high.
 */
module kms_key_matrix
	import kms_pkg::*;
(
	input wire logic [KMS_ROWS-1:0] row_oe,
	input wire logic [KMS_KEYS-1:0] pressed,
	output logic [KMS_COLS-1:0] col_in
);
	// a column idles high through its pull-up
	// a closed switch on a sunk row drags the column low
	// limitation: sneak paths between switches are not modelled
	always_comb begin
		col_in = '1;
		for (int r = 0; r < KMS_ROWS; r++) begin
			for (int c = 0; c < KMS_COLS; c++) begin
				if (row_oe[r] && pressed[r*KMS_COLS+c]) begin
					col_in[c] = 1'b0;
				end
			end
		end
	end
endmodule : kms_key_matrix

// ---- kms_pkg.sv ----
/*
 * kms_pkg: shared constants, register map, field layout, marker codes and
 * types for the key matrix scanner and its key queue.
 * Assumes a single 25 MHz clock and an AXI4-Lite register port with 24-bit
 * byte addresses.
 */
package kms_pkg;
	// matrix geometry and queue size
	localparam int unsigned KMS_ROWS = 8;
	localparam int unsigned KMS_COLS = 18;
	localparam int unsigned KMS_KEYS = KMS_ROWS * KMS_COLS;
	localparam int unsigned KMS_DEPTH = 32;
	localparam int unsigned KMS_PTR_W = 5;
	localparam int unsigned KMS_MAX_KEYS = 8;
	// timing: scan ticks come from the 128 kHz scan rate
	localparam int unsigned KMS_CLK_HZ = 25_000_000;
	localparam int unsigned KMS_TICK_HZ = 128_000;
	localparam int unsigned KMS_TICK_CYCLES = KMS_CLK_HZ / KMS_TICK_HZ;
	localparam logic [4:0] KMS_SETTLE_TICKS = 5'h04;
	localparam logic [2:0] KMS_SRST_CYCLES = 3'h4;
	// register byte addresses
	localparam logic [23:0] KMS_OFF_CTRL = 24'h226000;
	localparam logic [23:0] KMS_OFF_DEB = 24'h226004;
	localparam logic [23:0] KMS_OFF_IRQ_EN = 24'h226008;
	localparam logic [23:0] KMS_OFF_FLAG = 24'h22600C;
	localparam logic [23:0] KMS_OFF_QUEUE = 24'h226010;
	localparam logic [23:0] KMS_OFF_STATUS = 24'h226014;
	localparam logic [23:0] KMS_OFF_SRST = 24'h226018;
	// field positions
	localparam int unsigned KMS_CTRL_EN_BIT = 0;
	localparam int unsigned KMS_CTRL_ROW_LSB = 1;
	localparam int unsigned KMS_CTRL_COL_LSB = 4;
	localparam int unsigned KMS_DEB_PRESS_LSB = 0;
	localparam int unsigned KMS_DEB_REL_LSB = 4;
	localparam int unsigned KMS_ST_IDLE_BIT = 0;
	localparam int unsigned KMS_ST_EMPTY_BIT = 1;
	localparam int unsigned KMS_ST_FULL_BIT = 2;
	localparam int unsigned KMS_SRST_BIT = 0;
	localparam int unsigned KMS_BUSY_BIT = 1;
	localparam int unsigned KMS_IRQ_BIT = 0;
	// writable bits of the control word; higher bits always read zero
	localparam logic [31:0] KMS_CTRL_MASK = 32'h000001FF;
	// reset values: 8 rows, 18 columns, disabled; debounce 2 and 2
	localparam logic [31:0] KMS_CTRL_RST = 32'h0000011E;
	localparam logic [31:0] KMS_DEB_RST = 32'h00000022;
	localparam logic KMS_IRQ_EN_RST = 1'h0;
	localparam logic KMS_FLAG_RST = 1'h0;
	// end markers
	localparam logic [7:0] KMS_MK_FIRST = 8'hF7;
	localparam logic [7:0] KMS_MK_RELEASE = 8'hFF;
	localparam logic [7:0] KMS_MK_OVERFLOW = 8'hFE;
	localparam logic [7:0] KMS_MK_FULL_MORE8 = 8'hFD;
	localparam logic [7:0] KMS_MK_FULL_NORMAL = 8'hFC;
	localparam logic [7:0] KMS_MK_FULL_RELEASE = 8'hFB;
	localparam logic [7:0] KMS_MK_FULL_GHOST = 8'hFA;
	localparam logic [7:0] KMS_MK_GHOST = 8'hF9;
	localparam logic [7:0] KMS_MK_MORE8 = 8'hF8;
	localparam logic [7:0] KMS_MK_NORMAL = 8'hF7;
	// bus answers
	localparam logic [1:0] KMS_RESP_OKAY = 2'h0;
	localparam logic [1:0] KMS_RESP_SLVERR = 2'h2;

	// software configuration carried as one group
	typedef struct packed {
		logic en;
		logic [2:0] row_last;
		logic [4:0] col_last;
		logic [3:0] press_cnt;
		logic [3:0] rel_cnt;
	} kms_cfg_t;

	// scanner sequence
	typedef enum logic [3:0] {
		KMS_IDLE = 4'b0001,
		KMS_SCAN = 4'b0010,
		KMS_EVAL = 4'b0100,
		KMS_EMIT = 4'b1000
	} kms_state_t;
endpackage : kms_pkg

// ---- kms_scanner.sv ----
/*
 * kms_scanner: key matrix scanner with debounce, ghost detection, key queue
 * and an AXI4-Lite register port.
 * Assumes external pull-ups on rows and columns, open-drain row drivers in
 * the pad ring, and column pins asynchronous to aclk.
 */
// Functional notes
// - up to 8 rows by 18 columns
// - drive only the scanned row low
// - low column on driven row means pressed
// - scan lasts rows times columns-plus-four ticks
// - separate press and release debounce counts
// - codes 8 bits, 247 and up markers
// - codes ascend by column then row
// - push codes then one event marker
// - queue holds 32 eight-bit entries
// - marker encoding 247 through 255
// - over eight keys keeps first eight
// - ghost stores all keys then ghost marker
// - filling event gets full marker, scan stalls
// - lost keys record the overflow marker
// - event raises interrupt, enable bit resets off
// - flag cleared by writing one only
// - queue output in bits 7 to 0
// - status idle, empty and full bits
// - soft reset empties queue, busy bit
// - soft reset keeps the interrupt flag
module kms_scanner
	import kms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [23:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [23:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [KMS_ROWS-1:0] row_out,
	output logic [KMS_ROWS-1:0] row_oe,
	input wire logic [KMS_COLS-1:0] col_in,
	output logic key_event_irq
);
	kms_state_t state; // scanner sequence
	logic [31:0] ctrl_q; // scan control word
	logic [31:0] deb_q; // debounce counts
	kms_cfg_t cfg; // decoded configuration
	logic irq_en; // interrupt enable
	logic irq_flag; // sticky event flag
	logic [2:0] busy_cnt; // soft reset countdown
	logic busy; // soft reset in progress
	logic scan_rst; // clears scanner and queue
	logic [KMS_COLS-1:0] col_meta; // first sync stage, read only by col_sync
	logic [KMS_COLS-1:0] col_sync; // column levels on aclk
	logic [7:0] tick_cnt; // divider for the scan tick
	logic tick; // one pulse per scan period
	logic [2:0] row_idx; // row being driven
	logic [4:0] phase; // settle then column slot in this row
	logic [4:0] samp_col; // column sampled in this slot
	logic [7:0] samp_idx; // key index of that column
	logic [KMS_KEYS-1:0] raw; // this scan's pressed map
	logic [KMS_KEYS-1:0] last_raw; // previous scan's map
	logic [KMS_KEYS-1:0] report; // last reported map
	logic [3:0] stab_cnt; // identical consecutive scans
	logic [3:0] next_stab; // stab_cnt after this scan
	logic [3:0] thresh; // debounce count in force
	logic [7:0] npress; // keys pressed in raw
	logic ghost; // rectangle of pressed keys found
	logic [7:0] need; // queue slots the event needs
	logic [6:0] free; // free queue slots
	logic ev_fire; // debounced change found this cycle
	logic ev_ovf; // event does not fit
	logic [KMS_KEYS-1:0] ev_pat; // map being emitted
	logic ev_ghost; // emitted event is ghost
	logic ev_more8; // emitted event exceeds eight keys
	logic ev_release; // emitted event is all released
	logic [7:0] idx; // emit walk position
	logic [7:0] sent; // key codes pushed so far
	logic ovf_pend; // overflow marker owed
	logic push; // queue write
	logic [7:0] push_data; // queue write data
	logic pop; // queue read
	logic [7:0] q_head; // queue head entry
	logic [5:0] q_count; // queue fill level
	logic q_empty; // queue empty
	logic q_full; // queue full
	logic aw_hold; // write address held
	logic [23:0] aw_addr; // held write address
	logic w_hold; // write data held
	logic [31:0] w_data; // held write data
	logic [3:0] w_strb; // held byte strobes
	logic wr_go; // perform the write this cycle
	logic [31:0] wmask; // byte mask from strobes
	logic wr_flag; // write of the flag register

	assign cfg = '{en: ctrl_q[KMS_CTRL_EN_BIT], row_last: ctrl_q[KMS_CTRL_ROW_LSB +: 3],
		col_last: ctrl_q[KMS_CTRL_COL_LSB +: 5], press_cnt: deb_q[KMS_DEB_PRESS_LSB +: 4],
		rel_cnt: deb_q[KMS_DEB_REL_LSB +: 4]};
	assign busy = (busy_cnt != 3'h0);
	assign scan_rst = !aresetn || busy;
	assign q_empty = (q_count == 6'h00);
	assign q_full = (q_count == 6'(KMS_DEPTH));
	assign free = 7'(KMS_DEPTH) - {1'b0, q_count};
	assign key_event_irq = irq_flag && irq_en;

	// key queue; depth fixed at 32 bytes
	kms_key_fifo u_fifo (
		.aclk(aclk),
		.srst(scan_rst),
		.push(push),
		.push_data(push_data),
		.pop(pop),
		.head(q_head),
		.count(q_count)
	);

	// column pins are asynchronous: two flops before any use
	always_ff @(posedge aclk) begin
		col_meta <= col_in;
		col_sync <= col_meta;
	end

	// scan tick divider
	always_ff @(posedge aclk) begin
		if (scan_rst || tick) begin
			tick_cnt <= 8'h00;
		end else begin
			tick_cnt <= tick_cnt + 8'h01;
		end
	end
	assign tick = (tick_cnt == 8'(KMS_TICK_CYCLES - 1));

	// rows: only the scanned row is pulled low, the rest float high
	always_comb begin
		row_out = '0;
		row_oe = (state == KMS_SCAN) ? (KMS_ROWS'(1) << row_idx) : '0;
	end

	assign samp_col = phase - KMS_SETTLE_TICKS;
	assign samp_idx = 8'(row_idx * KMS_COLS) + {3'h0, samp_col};

	// scanner sequence: idle, scan, evaluate, emit
	always_ff @(posedge aclk) begin
		if (scan_rst) begin
			state <= KMS_IDLE;
			row_idx <= 3'h0;
			phase <= 5'h00;
			raw <= '0;
			idx <= 8'h00;
		end else begin
			unique case (state)
				KMS_IDLE: begin
					// a full queue or an owed overflow marker holds scanning off
					if (cfg.en && tick && !q_full && !ovf_pend) begin
						state <= KMS_SCAN;
						row_idx <= 3'h0;
						phase <= 5'h00;
						raw <= '0;
					end
				end
				KMS_SCAN: begin
					if (tick) begin
						// each row: four settle ticks then one per column
						if (phase >= KMS_SETTLE_TICKS) begin
							raw[samp_idx] <= !col_sync[samp_col];
						end
						if (phase == cfg.col_last + KMS_SETTLE_TICKS) begin
							phase <= 5'h00;
							if (row_idx == cfg.row_last) begin
								state <= KMS_EVAL;
							end else begin
								row_idx <= row_idx + 3'h1;
							end
						end else begin
							phase <= phase + 5'h01;
						end
					end
				end
				KMS_EVAL: begin
					state <= (ev_fire && !ev_ovf) ? KMS_EMIT : KMS_IDLE;
					idx <= 8'h00;
				end
				KMS_EMIT: begin
					idx <= idx + 8'h01;
					if (idx == 8'(KMS_KEYS)) begin
						state <= KMS_IDLE;
					end
				end
			endcase
		end
	end

	// pressed count and ghost rectangles over the scanned map
	always_comb begin
		npress = 8'h00;
		ghost = 1'b0;
		for (int k = 0; k < KMS_KEYS; k++) begin
			npress = npress + 8'(raw[k]);
		end
		for (int i = 0; i < KMS_ROWS; i++) begin
			for (int j = i + 1; j < KMS_ROWS; j++) begin
				int shared;
				shared = 0;
				for (int c = 0; c < KMS_COLS; c++) begin
					shared = shared + int'(raw[i*KMS_COLS+c] & raw[j*KMS_COLS+c]);
				end
				// two rows sharing two columns close a loop through the switches
				if (shared >= 2) begin
					ghost = 1'b1;
				end
			end
		end
	end

	// debounce decision and room check
	always_comb begin
		next_stab = (raw != last_raw) ? 4'h1 : ((stab_cnt == 4'hF) ? 4'hF : stab_cnt + 4'h1);
		thresh = (|(raw & ~report)) ? cfg.press_cnt : cfg.rel_cnt;
		if (thresh == 4'h0) begin
			thresh = 4'h1;
		end
		ev_fire = (state == KMS_EVAL) && (raw != report) && (next_stab >= thresh);
		if (ghost) begin
			need = npress + 8'h01;
		end else if (npress > 8'(KMS_MAX_KEYS)) begin
			need = 8'(KMS_MAX_KEYS + 1);
		end else begin
			need = npress + 8'h01;
		end
		ev_ovf = (need > {1'b0, free});
	end

	// debounce history and event snapshot
	always_ff @(posedge aclk) begin
		if (scan_rst) begin
			last_raw <= '0;
			report <= '0;
			stab_cnt <= 4'h0;
			ev_pat <= '0;
			ev_ghost <= 1'b0;
			ev_more8 <= 1'b0;
			ev_release <= 1'b0;
		end else if (state == KMS_EVAL) begin
			last_raw <= raw;
			stab_cnt <= next_stab;
			if (ev_fire) begin
				// a lost event still updates the reported map
				report <= raw;
				ev_pat <= raw;
				ev_ghost <= ghost;
				ev_more8 <= !ghost && (npress > 8'(KMS_MAX_KEYS));
				ev_release <= (npress == 8'h00);
			end
		end
	end

	// queue writer: codes in ascending order, then the marker
	always_comb begin
		push = 1'b0;
		push_data = 8'h00;
		if (state == KMS_EVAL && ev_fire && ev_ovf && !q_full) begin
			push = 1'b1;
			push_data = KMS_MK_OVERFLOW;
		end else if (state == KMS_EMIT && idx < 8'(KMS_KEYS)) begin
			// release maps are empty, so only the marker goes in
			push = ev_pat[idx] && (ev_ghost || sent < 8'(KMS_MAX_KEYS));
			push_data = idx;
		end else if (state == KMS_EMIT) begin
			push = 1'b1;
			if (ev_release) begin
				push_data = (free == 7'h01) ? KMS_MK_FULL_RELEASE : KMS_MK_RELEASE;
			end else if (ev_ghost) begin
				push_data = (free == 7'h01) ? KMS_MK_FULL_GHOST : KMS_MK_GHOST;
			end else if (ev_more8) begin
				push_data = (free == 7'h01) ? KMS_MK_FULL_MORE8 : KMS_MK_MORE8;
			end else begin
				push_data = (free == 7'h01) ? KMS_MK_FULL_NORMAL : KMS_MK_NORMAL;
			end
		end else if (state == KMS_IDLE && ovf_pend && !q_full) begin
			push = 1'b1;
			push_data = KMS_MK_OVERFLOW;
		end
	end

	// key codes pushed and the owed overflow marker
	always_ff @(posedge aclk) begin
		if (scan_rst) begin
			sent <= 8'h00;
			ovf_pend <= 1'b0;
		end else begin
			sent <= (state == KMS_EVAL) ? 8'h00 : sent + 8'(push && push_data < KMS_MK_FIRST);
			if (state == KMS_EVAL && ev_fire && ev_ovf && q_full) begin
				ovf_pend <= 1'b1;
			end else if (state == KMS_IDLE && push) begin
				ovf_pend <= 1'b0;
			end
		end
	end

	// bus write channels, taken in either order
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready = !w_hold && !s_axi_bvalid;
	assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	assign wr_flag = wr_go && (aw_addr == KMS_OFF_FLAG) && w_strb[0];

	// write address, data and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			aw_addr <= 24'h000000;
			w_hold <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= KMS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr)
					KMS_OFF_CTRL, KMS_OFF_DEB, KMS_OFF_IRQ_EN, KMS_OFF_FLAG, KMS_OFF_QUEUE,
						KMS_OFF_STATUS, KMS_OFF_SRST: s_axi_bresp <= KMS_RESP_OKAY;
					default: s_axi_bresp <= KMS_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= KMS_CTRL_RST;
			deb_q <= KMS_DEB_RST;
			irq_en <= KMS_IRQ_EN_RST;
		end else if (wr_go) begin
			if (aw_addr == KMS_OFF_CTRL) begin
				ctrl_q <= ((ctrl_q & ~wmask) | (w_data & wmask)) & KMS_CTRL_MASK;
			end
			if (aw_addr == KMS_OFF_DEB) begin
				deb_q <= ((deb_q & ~wmask) | (w_data & wmask)) & 32'h000000FF;
			end
			if (aw_addr == KMS_OFF_IRQ_EN && w_strb[0]) begin
				irq_en <= w_data[KMS_IRQ_BIT];
			end
		end
	end

	// event flag: cleared by the main reset or a write of one, not by soft reset; a new event beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag <= KMS_FLAG_RST;
		end else if (push && push_data >= KMS_MK_FIRST) begin
			irq_flag <= 1'b1;
		end else if (wr_flag && w_data[KMS_IRQ_BIT]) begin
			irq_flag <= 1'b0;
		end
	end

	// soft reset countdown; clears the scanner while busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cnt <= 3'h0;
		end else if (wr_go && aw_addr == KMS_OFF_SRST && w_strb[0] && w_data[KMS_SRST_BIT]) begin
			busy_cnt <= KMS_SRST_CYCLES;
		end else if (busy) begin
			busy_cnt <= busy_cnt - 3'h1;
		end
	end

	// read channel: one cycle to answer; a queue read pops the head
	assign s_axi_arready = !s_axi_rvalid;
	assign pop = s_axi_arvalid && s_axi_arready && (s_axi_araddr == KMS_OFF_QUEUE) && !q_empty
		&& !busy;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= KMS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= KMS_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			unique case (s_axi_araddr)
				KMS_OFF_CTRL: s_axi_rdata <= ctrl_q;
				KMS_OFF_DEB: s_axi_rdata <= deb_q;
				KMS_OFF_IRQ_EN: s_axi_rdata <= {31'h0, irq_en};
				KMS_OFF_FLAG: s_axi_rdata <= {31'h0, irq_flag};
				KMS_OFF_QUEUE: s_axi_rdata <= {24'h0, q_head};
				KMS_OFF_STATUS: s_axi_rdata <= {29'h0, q_full, q_empty, state == KMS_IDLE};
				KMS_OFF_SRST: s_axi_rdata <= {30'h0, busy, 1'b0};
				default: s_axi_rresp <= KMS_RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// helper: ticks spent in one scan
	logic [8:0] scan_ticks;
	always_ff @(posedge aclk) begin
		if (scan_rst || state != KMS_SCAN) begin
			scan_ticks <= 9'h000;
		end else if (tick) begin
			scan_ticks <= scan_ticks + 9'h001;
		end
	end

	AST_SCAN_LEN: assert property (@(posedge aclk) disable iff (scan_rst)
		(state == KMS_SCAN && tick && $past(state) == KMS_SCAN) ##1 state == KMS_EVAL
		|-> scan_ticks == 9'((cfg.row_last + 1) * (cfg.col_last + 5)))
		else $error("scan length wrong");
	AST_ROW_ONE: assert property (@(posedge aclk) disable iff (scan_rst)
		state == KMS_SCAN |-> $onehot(row_oe) && row_out == '0)
		else $error("row drive not one-hot");
	AST_ROW_OFF: assert property (@(posedge aclk) disable iff (scan_rst)
		state != KMS_SCAN |-> row_oe == '0)
		else $error("row driven outside scan");
	AST_CODE_RANGE: assert property (@(posedge aclk) disable iff (scan_rst)
		push && state == KMS_EMIT && idx < 8'(KMS_KEYS) |-> push_data < KMS_MK_FIRST)
		else $error("key code in marker range");
	AST_MAX8: assert property (@(posedge aclk) disable iff (scan_rst)
		state == KMS_EMIT && !ev_ghost |-> sent <= 8'(KMS_MAX_KEYS))
		else $error("more than eight codes");
	AST_RELEASE_ONLY: assert property (@(posedge aclk) disable iff (scan_rst)
		state == KMS_EMIT && ev_release && push |-> push_data >= KMS_MK_FIRST)
		else $error("code pushed on release");
	AST_IRQ_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		push && push_data >= KMS_MK_FIRST |=> irq_flag && (key_event_irq == irq_en))
		else $error("event did not raise flag");
	AST_FLAG_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_flag && !(wr_flag && w_data[0]) |=> irq_flag)
		else $error("flag lost without clear");
	AST_FULL_STALL: assert property (@(posedge aclk) disable iff (scan_rst)
		state == KMS_IDLE && q_full |=> state == KMS_IDLE)
		else $error("scan started while full");
	AST_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
		busy_cnt == KMS_SRST_CYCLES |-> busy [*4] ##1 !busy)
		else $error("busy length wrong");
	AST_RD_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");

	COV_NORMAL: cover property (@(posedge aclk) push && push_data == KMS_MK_NORMAL);
	COV_GHOST: cover property (@(posedge aclk) push && push_data == KMS_MK_GHOST);
	COV_OVF: cover property (@(posedge aclk) push && push_data == KMS_MK_OVERFLOW);
	COV_SRST: cover property (@(posedge aclk) busy ##1 !busy);
endmodule : kms_scanner
